// ---- itm_pkg.sv ----
package itm_pkg;

  // Register byte addresses
  localparam logic [31:0] PERIPH_CLOCK_ENABLE0_ADDR  = 32'h4002_0420;
  localparam logic [31:0] COUNT_CLOCK_SELECTION_ADDR = 32'h4004_0C0C;
  localparam logic [31:0] INTERVAL_CONTROL_ADDR      = 32'h4004_2400;
  localparam logic [31:0] INTERRUPT_STATUS_ADDR      = 32'h4004_2404;
  localparam logic [31:0] INTERRUPT_MASK_ADDR        = 32'h4004_2408;

  // Reset values
  localparam logic [7:0]  PERIPH_CLOCK_ENABLE0_RESET  = 8'h00;
  localparam logic [7:0]  COUNT_CLOCK_SELECTION_RESET = 8'h00;
  localparam logic [15:0] INTERVAL_CONTROL_RESET      = 16'h7FFF;
  localparam logic        INTERRUPT_MASK_RESET        = 1'b1;

  // Field positions and widths
  localparam int TIMER_CLOCK_GATE_BIT        = 7;
  localparam int MAIN_SOURCE_SELECT_BIT      = 7;
  localparam int MAIN_DIVIDER_SELECT_HI_BIT  = 6;
  localparam int MAIN_DIVIDER_SELECT_LO_BIT  = 5;
  localparam int COUNT_CLOCK_SELECT_HI_BIT   = 1;
  localparam int COUNT_CLOCK_SELECT_LO_BIT   = 0;
  localparam int INTERVAL_RUN_BIT            = 15;
  localparam int COMPARE_WIDTH               = 15;
  localparam int DIVISOR_WIDTH               = 11;

  // Writable bits of the count clock selection register
  localparam logic [7:0] COUNT_CLOCK_SELECTION_MASK = 8'hE3;

  // Count clock select field
  localparam logic [1:0] CKS_SUB_CLOCK  = 2'h0;
  localparam logic [1:0] CKS_LOW_SPEED  = 2'h1;
  localparam logic [1:0] CKS_MAIN_SLOW  = 2'h2;
  localparam logic [1:0] CKS_MAIN_FAST  = 2'h3;

  // Main divider select field
  localparam logic [1:0] MDS_00 = 2'h0;
  localparam logic [1:0] MDS_01 = 2'h1;
  localparam logic [1:0] MDS_10 = 2'h2;

  // Divisors of the selected source clock, in source cycles
  localparam logic [10:0] DIVIDE_NONE = 11'h001;
  localparam logic [10:0] DIVIDE_1952 = 11'h7A0;
  localparam logic [10:0] DIVIDE_1464 = 11'h5B8;
  localparam logic [10:0] DIVIDE_976  = 11'h3D0;
  localparam logic [10:0] DIVIDE_488  = 11'h1E8;
  localparam logic [10:0] DIVIDE_244  = 11'h0F4;
  localparam logic [10:0] DIVIDE_OFF  = 11'h000;

endpackage : itm_pkg

// ---- itm_count_clock_divider.sv ----
`timescale 1ns/1ps

module itm_count_clock_divider #(
  parameter int DIVISOR_WIDTH = 11
) (
  input  wire logic                     clock,        // System clock
  input  wire logic                     resetn,       // Synchronised reset, active low
  input  wire logic                     enable,       // Divider running
  input  wire logic                     sourceLevel,  // Selected source clock level
  input  wire logic [DIVISOR_WIDTH-1:0] divisor,      // Source edges per tick
  output logic                          tick          // One-cycle count clock pulse
);

  logic                     previousLevel;
  logic [DIVISOR_WIDTH-1:0] edgeCount;
  wire                      risingEdge;
  wire                      lastEdge;
  wire  [DIVISOR_WIDTH-1:0] countPlusOne;

  assign risingEdge   = sourceLevel & ~previousLevel;
  assign lastEdge     = (edgeCount >= divisor - DIVISOR_WIDTH'(1));
  assign countPlusOne = edgeCount + DIVISOR_WIDTH'(1);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      previousLevel <= 1'b0;
    end else begin
      previousLevel <= sourceLevel;
    end
  end

  // Disabled divider restarts from zero so the first tick is a full period
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      edgeCount <= '0;
      tick      <= 1'b0;
    end else if (!enable) begin
      edgeCount <= '0;
      tick      <= 1'b0;
    end else if (risingEdge && lastEdge) begin
      edgeCount <= '0;
      tick      <= 1'b1;
    end else if (risingEdge) begin
      edgeCount <= countPlusOne;
      tick      <= 1'b0;
    end else begin
      tick      <= 1'b0;
    end
  end

endmodule : itm_count_clock_divider

// ---- itm_interval_timer.sv ----
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

module itm_interval_timer #(
  parameter int COMPARE_WIDTH = itm_pkg::COMPARE_WIDTH
) (
  input  wire logic        clock,                // 40 MHz register clock
  input  wire logic        resetn,               // Asynchronous reset, active low
  input  wire logic [31:0] address,              // Register byte address
  input  wire logic [31:0] writeData,            // Write data
  input  wire logic        writeStrobe,          // One-cycle write request
  input  wire logic        readStrobe,           // One-cycle read request
  output logic      [31:0] readData,             // Read data, cycle after strobe
  input  wire logic        subClock,             // Sub clock level
  input  wire logic        lowSpeedOscClock,     // Low-speed oscillator level
  input  wire logic        highSpeedSystemClock, // High-speed system clock level
  input  wire logic        highSpeedInternalOsc, // High-speed internal osc level
  input  wire logic        lowSpeedOscSelect,    // Low-speed osc routed to timers
  output logic             intervalInterrupt,    // One-cycle pulse per match
  output logic             irq                   // Level interrupt request
);

  // Reset release through two flip-flops
  logic [1:0] resetSync;
  wire        rstn;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resetSync <= 2'b00;
    end else begin
      resetSync <= {resetSync[0], 1'b1};
    end
  end

  assign rstn = resetSync[1];

  // Registers
  logic [7:0]               periphClockEnable0;
  logic [7:0]               countClockSelection;
  logic [15:0]              pendingControl;
  logic [15:0]              appliedControl;
  logic [COMPARE_WIDTH-1:0] counter;
  logic                     intervalInterruptFlag;
  logic                     interruptMask;

  // Address decode
  wire hitEnable    = (address == itm_pkg::PERIPH_CLOCK_ENABLE0_ADDR);
  wire hitSelection = (address == itm_pkg::COUNT_CLOCK_SELECTION_ADDR);
  wire hitControl   = (address == itm_pkg::INTERVAL_CONTROL_ADDR);
  wire hitStatus    = (address == itm_pkg::INTERRUPT_STATUS_ADDR);
  wire hitMask      = (address == itm_pkg::INTERRUPT_MASK_ADDR);

  wire timerClockGate = periphClockEnable0[itm_pkg::TIMER_CLOCK_GATE_BIT];

  wire writeEnable    = writeStrobe & hitEnable;
  wire writeSelection = writeStrobe & hitSelection & timerClockGate;
  wire writeControl   = writeStrobe & hitControl & timerClockGate;
  wire writeMask      = writeStrobe & hitMask;
  wire readStatus     = readStrobe & hitStatus;

  // Clock selection fields
  wire       mainSourceSelect = countClockSelection[itm_pkg::MAIN_SOURCE_SELECT_BIT];
  wire [1:0] countClockSelect = {countClockSelection[itm_pkg::COUNT_CLOCK_SELECT_HI_BIT],
                                 countClockSelection[itm_pkg::COUNT_CLOCK_SELECT_LO_BIT]};
  wire [1:0] mainDividerSelect = {countClockSelection[itm_pkg::MAIN_DIVIDER_SELECT_HI_BIT],
                                  countClockSelection[itm_pkg::MAIN_DIVIDER_SELECT_LO_BIT]};

  // Divisor for a select pair; zero marks a combination with no clock
  function automatic logic [10:0] itm_divisor(input logic [1:0] cks,
                                              input logic [1:0] mds,
                                              input logic       lowSpeedOk);
    logic [10:0] result;
    result = itm_pkg::DIVIDE_OFF;
    case (cks)
      itm_pkg::CKS_SUB_CLOCK: begin
        result = itm_pkg::DIVIDE_NONE;
      end
      itm_pkg::CKS_LOW_SPEED: begin
        result = lowSpeedOk ? itm_pkg::DIVIDE_NONE : itm_pkg::DIVIDE_OFF;
      end
      itm_pkg::CKS_MAIN_SLOW: begin
        case (mds)
          itm_pkg::MDS_01: result = itm_pkg::DIVIDE_1952;
          itm_pkg::MDS_00: result = itm_pkg::DIVIDE_1464;
          itm_pkg::MDS_10: result = itm_pkg::DIVIDE_976;
          default:         result = itm_pkg::DIVIDE_OFF;
        endcase
      end
      itm_pkg::CKS_MAIN_FAST: begin
        case (mds)
          itm_pkg::MDS_00: result = itm_pkg::DIVIDE_488;
          itm_pkg::MDS_10: result = itm_pkg::DIVIDE_244;
          default:         result = itm_pkg::DIVIDE_OFF;
        endcase
      end
      default: begin
        result = itm_pkg::DIVIDE_OFF;
      end
    endcase
    return result;
  endfunction : itm_divisor

  wire        mainClockLevel = mainSourceSelect ? highSpeedInternalOsc
                                                : highSpeedSystemClock;
  wire        selectedLevel  = (countClockSelect == itm_pkg::CKS_SUB_CLOCK) ? subClock
                             : (countClockSelect == itm_pkg::CKS_LOW_SPEED) ? lowSpeedOscClock
                             : mainClockLevel;
  wire [10:0] countDivisor   = itm_divisor(countClockSelect, mainDividerSelect,
                                           lowSpeedOscSelect);
  // Gate low or an unlisted select pair gives no count clock at all
  wire        countEnable    = timerClockGate & (countDivisor != itm_pkg::DIVIDE_OFF);
  wire        countTick;

  itm_count_clock_divider #(
    .DIVISOR_WIDTH (itm_pkg::DIVISOR_WIDTH)
  ) itm_count_clock_divider_i (
    .clock       (clock),
    .resetn      (rstn),
    .enable      (countEnable),
    .sourceLevel (selectedLevel),
    .divisor     (countDivisor),
    .tick        (countTick)
  );

  // Register writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      periphClockEnable0 <= itm_pkg::PERIPH_CLOCK_ENABLE0_RESET;
    end else if (writeEnable) begin
      periphClockEnable0 <= writeData[7:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      countClockSelection <= itm_pkg::COUNT_CLOCK_SELECTION_RESET;
    end else if (writeSelection) begin
      countClockSelection <= writeData[7:0] & itm_pkg::COUNT_CLOCK_SELECTION_MASK;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interruptMask <= itm_pkg::INTERRUPT_MASK_RESET;
    end else if (writeMask) begin
      interruptMask <= writeData[0];
    end
  end

  // Written value waits here until the next count clock tick
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pendingControl <= itm_pkg::INTERVAL_CONTROL_RESET;
    end else if (!timerClockGate) begin
      pendingControl <= itm_pkg::INTERVAL_CONTROL_RESET;
    end else if (writeControl) begin
      pendingControl <= writeData[15:0];
    end
  end

  // Copy taken only on a tick, so the counter never sees a half-applied write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      appliedControl <= itm_pkg::INTERVAL_CONTROL_RESET;
    end else if (!timerClockGate) begin
      appliedControl <= itm_pkg::INTERVAL_CONTROL_RESET;
    end else if (countTick) begin
      appliedControl <= pendingControl;
    end
  end

  wire                     intervalRun  = appliedControl[itm_pkg::INTERVAL_RUN_BIT];
  wire [COMPARE_WIDTH-1:0] compareValue = appliedControl[COMPARE_WIDTH-1:0];
  wire                     counterMatch = (counter == compareValue);
  wire [COMPARE_WIDTH-1:0] counterNext  = counter + COMPARE_WIDTH'(1);

  // Counter runs on ticks only, independent of any processor sleep state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      counter           <= '0;
      intervalInterrupt <= 1'b0;
    end else if (!timerClockGate) begin
      counter           <= '0;
      intervalInterrupt <= 1'b0;
    end else if (!intervalRun) begin
      // Stopped clears at once, so a frozen count clock cannot leave a stale count
      counter           <= '0;
      intervalInterrupt <= 1'b0;
    end else if (countTick && counterMatch) begin
      counter           <= '0;
      intervalInterrupt <= 1'b1;
    end else if (countTick) begin
      counter           <= counterNext;
      intervalInterrupt <= 1'b0;
    end else begin
      intervalInterrupt <= 1'b0;
    end
  end

  // Sticky flag; a new match in the clearing read's cycle is kept
  wire nextIntervalInterruptFlag = (intervalInterruptFlag & ~readStatus) | intervalInterrupt;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intervalInterruptFlag <= 1'b0;
    end else begin
      intervalInterruptFlag <= nextIntervalInterruptFlag;
    end
  end

  assign irq = intervalInterruptFlag & ~interruptMask;

  // Read path; run bit shows the applied copy, compare shows the written one
  wire [31:0] controlReadValue = {16'h0000, intervalRun, pendingControl[COMPARE_WIDTH-1:0]};
  wire [31:0] readMux = hitEnable    ? {24'h000000, periphClockEnable0}
                      : hitSelection ? {24'h000000, countClockSelection}
                      : hitControl   ? controlReadValue
                      : hitStatus    ? {31'h00000000, intervalInterruptFlag}
                      : hitMask      ? {31'h00000000, interruptMask}
                      : 32'h00000000;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readData <= 32'h00000000;
    end else if (readStrobe) begin
      readData <= readMux;
    end else begin
      readData <= 32'h00000000;
    end
  end

endmodule : itm_interval_timer

// ---- itm_interval_timer_asserts.sv ----
`timescale 1ns/1ps
module itm_interval_timer_chk (
  input wire logic        clock,             // Register clock
  input wire logic        resetn,            // Reset, active low
  input wire logic [31:0] address,           // Byte address
  input wire logic [31:0] writeData,         // Write data
  input wire logic        writeStrobe,       // Write request
  input wire logic        readStrobe,        // Read request
  input wire logic [31:0] readData,          // Read data
  input wire logic        intervalInterrupt, // Match pulse
  input wire logic        irq                // Level request
);
  logic [7:0] enableCopy;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enableCopy <= 8'h00;
    end else if (writeStrobe && address == itm_pkg::PERIPH_CLOCK_ENABLE0_ADDR) begin
      enableCopy <= writeData[7:0];
    end
  end
  wire gateOn = enableCopy[itm_pkg::TIMER_CLOCK_GATE_BIT];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_read(logic [31:0] a);
    readStrobe && address == a;
  endsequence
  // Gate must have been low long enough for the forced values to settle
  sequence s_gate_off;
    !(gateOn || $past(gateOn) || $past(gateOn, 2));
  endsequence
  property p_idle; !readStrobe |=> readData == 32'h0000_0000; endproperty
  property p_enable_back;
    s_read(itm_pkg::PERIPH_CLOCK_ENABLE0_ADDR) |=> readData == {24'h000000, enableCopy};
  endproperty
  property p_sel_back;
    s_read(itm_pkg::COUNT_CLOCK_SELECTION_ADDR) |=> readData[31:8] == 24'h0 && readData[4:2] == 3'h0;
  endproperty
  property p_ctl_off;
    s_read(itm_pkg::INTERVAL_CONTROL_ADDR) ##0 s_gate_off |=> readData == 32'h0000_7FFF;
  endproperty
  property p_no_pulse_off; s_gate_off |-> !intervalInterrupt; endproperty
  property p_pulse_one; intervalInterrupt |=> !intervalInterrupt; endproperty
  property p_irq_rise;
    $rose(irq) |-> $past(intervalInterrupt) || $past(intervalInterrupt, 2) ||
      $past(writeStrobe && address == itm_pkg::INTERRUPT_MASK_ADDR);
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(readStrobe && address == itm_pkg::INTERRUPT_STATUS_ADDR) ||
      $past(writeStrobe && (address == itm_pkg::INTERRUPT_MASK_ADDR ||
      address == itm_pkg::PERIPH_CLOCK_ENABLE0_ADDR));
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_enable_back: assert property (p_enable_back) else $error("enable readback wrong");
  a_sel_back: assert property (p_sel_back) else $error("selection spare bits set");
  a_ctl_off: assert property (p_ctl_off) else $error("control not held");
  a_no_pulse_off: assert property (p_no_pulse_off) else $error("pulse with gate low");
  a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
endmodule : itm_interval_timer_chk
bind itm_interval_timer itm_interval_timer_chk itm_interval_timer_chk_i (.clock(clock),
  .resetn(resetn), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .intervalInterrupt(intervalInterrupt), .irq(irq));

// ---- itm_interval_timer_tb_top.sv ----
`timescale 1ns/1ps
module itm_interval_timer_tb_top;
  localparam logic [31:0] EN  = itm_pkg::PERIPH_CLOCK_ENABLE0_ADDR;
  localparam logic [31:0] SEL = itm_pkg::COUNT_CLOCK_SELECTION_ADDR;
  localparam logic [31:0] CTL = itm_pkg::INTERVAL_CONTROL_ADDR;
  localparam logic [31:0] STS = itm_pkg::INTERRUPT_STATUS_ADDR;
  localparam logic [31:0] MSK = itm_pkg::INTERRUPT_MASK_ADDR;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] address = 32'h0;
  logic [31:0] writeData = 32'h0;
  logic        writeStrobe = 1'b0;
  logic        readStrobe = 1'b0;
  logic        lowSpeedOscSelect = 1'b0;
  logic [2:0]  divCnt = 3'h0;
  wire  [31:0] readData;
  wire         intervalInterrupt;
  wire         irq;
  int          errorCnt = 0;
  int          checkCount = 0;
  int          n;
  // Main source periods: system clock 2 cycles, internal osc 4 cycles
  logic [7:0]  selTab [6] = '{8'h22, 8'h02, 8'h42, 8'h03, 8'h43, 8'hC3};
  int          perTab [6] = '{7808, 5856, 3904, 1952, 976, 1952};
  always #12.5 clock = ~clock;
  always @(posedge clock) divCnt <= divCnt + 3'h1;
  itm_interval_timer itm_interval_timer_i (.clock(clock), .resetn(resetn), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .subClock(divCnt[1]), .lowSpeedOscClock(divCnt[2]),
    .highSpeedSystemClock(divCnt[0]), .highSpeedInternalOsc(divCnt[1]),
    .lowSpeedOscSelect(lowSpeedOscSelect), .intervalInterrupt(intervalInterrupt), .irq(irq));
  task automatic closeOut;
    if (errorCnt == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : closeOut
  task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
    checkCount++;
    if (s !== e) begin
      $display("[FAIL] %s expected %0h seen %0h", name, e, s);
      errorCnt++;
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : wr
  task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] e);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    @(negedge clock);
    chk(name, readData, e);
  endtask : rdchk
  // A missing pulse ends the run, since later steps depend on it
  task automatic waitPulse(input int limit, output int cnt);
    cnt = 0;
    do begin
      @(negedge clock);
      cnt++;
    end while (cnt < limit && intervalInterrupt !== 1'b1);
    if (intervalInterrupt !== 1'b1) begin
      errorCnt++;
      closeOut();
    end
  endtask : waitPulse
  // First period after a start may be short, so time the second
  task automatic measure(input string name, input int e);
    int cnt;
    waitPulse(40000, cnt);
    waitPulse(40000, cnt);
    chk(name, 32'(cnt), 32'(e));
  endtask : measure
  task automatic quiet(input int cycles);
    int hits;
    hits = 0;
    repeat (cycles) begin
      @(negedge clock);
      if (intervalInterrupt === 1'b1) hits++;
    end
    chk("no pulse", 32'(hits), 32'h0);
  endtask : quiet
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rdchk("enable", EN, 32'h0);
    rdchk("select", SEL, 32'h0);
    rdchk("control", CTL, 32'h7FFF);
    rdchk("mask", MSK, 32'h1);
    rdchk("status", STS, 32'h0);
    rdchk("unmapped", 32'h4004_2410, 32'h0);
    wr(CTL, 32'h8003);
    wr(SEL, 32'h02);
    rdchk("control locked", CTL, 32'h7FFF);
    rdchk("select locked", SEL, 32'h0);
    quiet(64);
    wr(EN, 32'hFF);
    rdchk("enable on", EN, 32'hFF);
    wr(SEL, 32'hFF);
    rdchk("select bits", SEL, 32'hE3);
    for (int i = 0; i < 6; i++) begin
      wr(SEL, {24'h0, selTab[i]});
      wr(CTL, 32'h8001);
      if (i == 0) rdchk("run lag", CTL, 32'h0001);
      measure("divided period", perTab[i]);
      if (i == 0) rdchk("run applied", CTL, 32'h8001);
      wr(CTL, 32'h0001);
    end
    wr(SEL, 32'h01);
    wr(CTL, 32'h8001);
    quiet(200);
    wr(CTL, 32'h0001);
    lowSpeedOscSelect <= 1'b1;
    wr(CTL, 32'h8001);
    measure("low speed period", 16);
    wr(CTL, 32'h0003);
    wr(SEL, 32'h60);
    wr(CTL, 32'h8003);
    measure("sub period", 16);
    // Flag is set one cycle after the pulse; the mask must still hide it
    @(negedge clock);
    chk("irq masked", irq, 32'h0);
    rdchk("flag", STS, 32'h1);
    rdchk("flag cleared", STS, 32'h0);
    wr(MSK, 32'h0);
    waitPulse(100, n);
    @(negedge clock);
    chk("irq set", irq, 32'h1);
    rdchk("flag read", STS, 32'h1);
    chk("irq clear", irq, 32'h0);
    wr(MSK, 32'h1);
    wr(CTL, 32'h0003);
    wr(CTL, 32'h8003);
    wr(EN, 32'h0);
    rdchk("control reset", CTL, 32'h7FFF);
    quiet(100);
    rdchk("select kept", SEL, 32'h60);
    closeOut();
  end
endmodule : itm_interval_timer_tb_top
